// File: hw/tws_pkg.sv
// Constants and types shared by the three-wire serial control port
package tws_pkg;
	// ------------------------------------------------------------------
	// Serial map
	// ------------------------------------------------------------------
	localparam int NREG = 53;
	localparam logic [12:0] ADDR_CTRL = 13'h0000;
	localparam logic [12:0] ADDR_RDBK = 13'h0004;
	localparam logic [12:0] ADDR_UPDT = 13'h0005;
	localparam logic [12:0] ADDR_TOP = 13'h0034;
	localparam int CTRL_LSB_BIT = 6;
	localparam int CTRL_SRST_BIT = 5;
	localparam int CTRL_SRST_MIR = 2;
	localparam int RDBK_BIT = 0;
	localparam int UPDT_BIT = 0;
	localparam logic [7:0] REG_DEFAULT = 8'h00;
	localparam logic [7:0] CTRL_DEFAULT = 8'h18;
	// ------------------------------------------------------------------
	// Instruction word layout
	// ------------------------------------------------------------------
	localparam int INSTR_BITS = 16;
	localparam int INSTR_DIR_BIT = 15;
	localparam int INSTR_LEN_HI = 14;
	localparam int INSTR_LEN_LO = 13;
	localparam logic [1:0] LEN_STREAM = 2'h3;
	localparam int BYTE_BITS = 8;
	// ------------------------------------------------------------------
	// Bus register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [6:0] IDX_STATUS = 7'h40;
	localparam logic [6:0] IDX_CONTROL = 7'h41;
	localparam int CONTROL_EN_BIT = 0;
	localparam logic CONTROL_EN_RESET = 1'b1;
	// Port phases
	typedef enum logic [1:0] {
		TWS_IDLE = 2'b00,
		TWS_INSTR = 2'b01,
		TWS_DATA = 2'b10,
		TWS_STALL = 2'b11
	} tws_phase_t;
endpackage

// File: hw/tws_port.sv
// Three-wire serial control port with shadowed register map and AHB view
`timescale 1ns/1ps

// How it works
// - Bits are taken on sclk rising edges; read bits launch on falling edges.
// - The data pin is released whenever select is high.
// - Each cycle opens with a sixteen bit instruction.
// - Instruction: bit 15 direction, bits 14:13 length, bits 12:0 address.
// - Direction 0 writes data bytes into the shadow buffers.
// - Direction 1 shifts out register bytes from the start address.
// - Length 00/01/10 gives one, two or three bytes; 11 streams.
// - Streaming runs until the host raises select after the last byte.
// - Short writes may stall on byte boundaries; the port waits. Read data bytes never stall.
// - A stalled transfer resumes where it stopped when select falls.
// - Abort by finishing bytes or a short partial-byte select pulse.
// - Select rising mid-byte ends the transfer and drops partial data.
// - Read-only bytes ignore writes; writable ones land in shadows, except 0x04 and 0x05, which act at once.
// - Update bit at 0x05 copies all shadows to active at once.
// - Readback bit at 0x04 picks shadow instead of active values.
// - Only the sixteen bit instruction format exists.
// - Bit order is MSB first until LSB-first bit is updated in.
// - MSB first: address decrements per further byte.
// - LSB first: address increments per further byte toward 0x34.
// - Stepping visits every address, unused ones too.
// - Read data leaves on the same data pin.
// - The update bit clears itself after the copy.
// - Soft reset restores defaults and clears itself.
// - Control byte mirrors high nibble; bit 7 reads 0, bit 4 reads 1.
module tws_port
	import tws_pkg::*;
(
	input wire logic clk, // System clock, 125 MHz
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write flag
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic [31:0] hrdata, // AHB read data
	output logic hresp, // AHB response, always OKAY
	input wire logic sclk, // Serial shift clock pin
	input wire logic cs_n, // Serial select pin, active low
	input wire logic sdio_in, // Data pin level
	output logic sdio_out, // Data pin drive value
	output logic sdio_oe_n // Data pin enable, active low
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic sclk_s1, sclk_s2, sclk_s3;
		logic cs_s1, cs_s2, cs_s3;
		logic sd_s1, sd_s2;
		tws_phase_t phase;
		logic [4:0] bitcnt;
		logic [15:0] instr;
		logic dir;
		logic [1:0] len;
		logic [1:0] nbytes;
		logic done;
		logic [12:0] addr;
		logic [7:0] shreg;
		logic [7:0] outreg;
		logic [2:0] fallcnt;
		logic drive;
		logic sd_out;
		logic oe_n;
		logic [NREG-1:0][7:0] shadow;
		logic [NREG-1:0][7:0] active;
		logic rdbk;
		logic enable;
		logic [15:0] cycles;
		logic bus_wr;
		logic [6:0] bus_idx;
		logic [31:0] rdata;
	} tws_state_t;

	tws_state_t st;
	tws_state_t next_st;

	// Control byte as seen by the host: high nibble mirrored low
	function automatic logic [7:0] tws_ctrl_view(input logic [7:0] r);
		logic [3:0] hi;
		hi = {1'b0, r[CTRL_LSB_BIT], 1'b0, 1'b1};
		// Low nibble is the high one bit-reversed, giving 0x18 at reset
		return {hi, hi[0], hi[1], hi[2], hi[3]};
	endfunction

	// Byte returned to a serial read of one address
	function automatic logic [7:0] tws_read(input tws_state_t s,
			input logic [12:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_CTRL) begin
			v = tws_ctrl_view(s.active[0]);
		end else if (a == ADDR_RDBK) begin
			v = {7'h00, s.rdbk};
		end else if (a == ADDR_UPDT) begin
			v = 8'h00;
		end else if (a <= ADDR_TOP) begin
			v = s.rdbk ? s.shadow[a[5:0]] : s.active[a[5:0]];
		end
		return v;
	endfunction

	// Next address for multibyte runs; unused addresses are not skipped
	function automatic logic [12:0] tws_step(input logic [12:0] a,
			input logic lsb);
		return lsb ? a + 13'h0001 : a - 13'h0001;
	endfunction

	// Shift one serial bit into a byte in the active order
	function automatic logic [7:0] tws_shift(input logic [7:0] v,
			input logic b, input logic lsb);
		return lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	// Default register contents, used by soft reset
	function automatic logic [NREG-1:0][7:0] tws_defaults();
		logic [NREG-1:0][7:0] d;
		for (int i = 0; i < NREG; i++) begin
			d[i] = REG_DEFAULT;
		end
		d[0] = CTRL_DEFAULT;
		return d;
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic lsb;
		logic sclk_rise;
		logic sclk_fall;
		logic cs_rise;
		logic cs_fall;
		logic cs_low;
		logic [15:0] ins;
		logic [7:0] byte_in;
		logic [1:0] want;
		logic [6:0] idx;
		lsb = 1'b0;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		cs_rise = 1'b0;
		cs_fall = 1'b0;
		cs_low = 1'b0;
		ins = 16'h0000;
		byte_in = 8'h00;
		want = 2'h0;
		idx = 7'h00;
		next_st = st;

		// Pin sampling; the second and third stages feed logic
		next_st.sclk_s1 = sclk;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_s3 = st.sclk_s2;
		next_st.cs_s1 = cs_n;
		next_st.cs_s2 = st.cs_s1;
		next_st.cs_s3 = st.cs_s2;
		next_st.sd_s1 = sdio_in;
		next_st.sd_s2 = st.sd_s1;

		lsb = st.active[0][CTRL_LSB_BIT];
		cs_low = !st.cs_s2 && st.enable;
		sclk_rise = st.sclk_s2 && !st.sclk_s3 && cs_low;
		sclk_fall = !st.sclk_s2 && st.sclk_s3 && cs_low;
		cs_rise = st.cs_s2 && !st.cs_s3;
		cs_fall = !st.cs_s2 && st.cs_s3 && st.enable;
		want = st.len;

		// Select falling: start fresh unless a stall is pending
		if (cs_fall && st.phase != TWS_STALL) begin
			next_st.phase = TWS_INSTR;
			next_st.bitcnt = 5'h00;
			next_st.instr = 16'h0000;
		end else if (cs_fall) begin
			next_st.phase = st.dir && st.bitcnt == 5'(INSTR_BITS)
				? TWS_DATA : (st.bitcnt == 5'(INSTR_BITS)
				? TWS_DATA : TWS_INSTR);
		end

		// Rising sclk: instruction and write data bits
		if (sclk_rise && st.phase == TWS_INSTR) begin
			ins = lsb ? {st.sd_s2, st.instr[15:1]}
				: {st.instr[14:0], st.sd_s2};
			next_st.instr = ins;
			next_st.bitcnt = st.bitcnt + 5'h01;
			if (st.bitcnt == 5'(INSTR_BITS - 1)) begin
				next_st.phase = TWS_DATA;
				next_st.dir = ins[INSTR_DIR_BIT];
				next_st.len = ins[INSTR_LEN_HI:INSTR_LEN_LO];
				next_st.addr = ins[12:0];
				next_st.nbytes = 2'h0;
				next_st.done = 1'b0;
				next_st.fallcnt = 3'h0;
				next_st.outreg = tws_read(st, ins[12:0]);
			end
		end else if (sclk_rise && st.phase == TWS_DATA && !st.done) begin
			next_st.bitcnt = (st.bitcnt == 5'(INSTR_BITS + BYTE_BITS - 1))
				? 5'(INSTR_BITS) : st.bitcnt + 5'h01;
			if (!st.dir) begin
				byte_in = tws_shift(st.shreg, st.sd_s2, lsb);
				next_st.shreg = byte_in;
			end
			if (st.bitcnt == 5'(INSTR_BITS + BYTE_BITS - 1)) begin
				next_st.nbytes = st.nbytes + 2'h1;
				if (st.len != LEN_STREAM && st.nbytes == want) begin
					next_st.done = 1'b1;
				end
				if (!st.dir) begin
					next_st.addr = tws_step(st.addr, lsb);
					if (st.addr == ADDR_CTRL) begin
						next_st.shadow[0][CTRL_LSB_BIT] =
							byte_in[CTRL_LSB_BIT];
					end else if (st.addr == ADDR_RDBK) begin
						next_st.rdbk = byte_in[RDBK_BIT];
					end else if (st.addr == ADDR_UPDT) begin
						if (byte_in[UPDT_BIT]) begin
							next_st.active = st.shadow;
						end
					end else if (st.addr <= ADDR_TOP) begin
						next_st.shadow[st.addr[5:0]] = byte_in;
					end
					// Soft reset acts at once and is never stored
					if (st.addr == ADDR_CTRL && (byte_in[CTRL_SRST_BIT]
							|| byte_in[CTRL_SRST_MIR])) begin
						next_st.shadow = tws_defaults();
						next_st.active = tws_defaults();
						next_st.rdbk = 1'b0;
						next_st.phase = TWS_IDLE;
					end
				end
			end
		end

		// Falling sclk: launch read bits after the instruction
		if (sclk_fall && st.phase == TWS_DATA && st.dir) begin
			next_st.drive = 1'b1;
			next_st.sd_out = lsb ? st.outreg[0] : st.outreg[7];
			next_st.outreg = lsb ? {1'b0, st.outreg[7:1]}
				: {st.outreg[6:0], 1'b0};
			next_st.fallcnt = st.fallcnt + 3'h1;
			if (st.fallcnt == 3'h7) begin
				next_st.addr = tws_step(st.addr, lsb);
				next_st.outreg = tws_read(st, tws_step(st.addr, lsb));
			end
		end

		// Select rising: stall on a boundary, otherwise end the cycle
		if (cs_rise) begin
			next_st.drive = 1'b0;
			if ((st.phase == TWS_INSTR || st.phase == TWS_DATA)
					&& st.bitcnt[2:0] == 3'h0 && st.bitcnt != 5'h00
					&& st.len != LEN_STREAM && !st.done
					&& !(st.phase == TWS_DATA && st.dir)) begin
				next_st.phase = TWS_STALL;
			end else if (st.phase == TWS_STALL
					&& st.bitcnt[2:0] == 3'h0) begin
				next_st.phase = TWS_STALL;
			end else begin
				next_st.phase = TWS_IDLE;
				next_st.shreg = 8'h00;
				next_st.bitcnt = 5'h00;
				next_st.cycles = st.cycles + 16'h0001;
			end
		end
		if (st.cs_s2) begin
			next_st.drive = 1'b0;
		end

		// AHB data phase write and address phase capture
		if (st.bus_wr && st.bus_idx == IDX_CONTROL) begin
			next_st.enable = hwdata[CONTROL_EN_BIT];
			if (!hwdata[CONTROL_EN_BIT]) begin
				next_st.phase = TWS_IDLE;
				next_st.drive = 1'b0;
			end
		end
		next_st.bus_wr = 1'b0;
		if (hsel && htrans[1] && hready) begin
			idx = haddr[8:2];
			next_st.bus_wr = hwrite;
			next_st.bus_idx = idx;
			next_st.rdata = 32'h0000_0000;
			if (!hwrite && idx == IDX_STATUS) begin
				next_st.rdata = {st.cycles, 8'h00, 1'b0, st.done,
					st.len, lsb, st.drive, st.phase};
			end else if (!hwrite && idx == IDX_CONTROL) begin
				next_st.rdata = {31'h0, st.enable};
			end else if (!hwrite && idx <= ADDR_TOP[6:0]) begin
				next_st.rdata = {24'h0, tws_read(st, {6'h00, idx})};
			end
		end
		// Pin enable kept as its own flop so the output needs no gate
		next_st.oe_n = !next_st.drive;
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.sclk_s1 <= 1'b0;
			st.cs_s1 <= 1'b1;
			st.cs_s2 <= 1'b1;
			st.cs_s3 <= 1'b1;
			st.phase <= TWS_IDLE;
			st.shadow <= {NREG{REG_DEFAULT}};
			st.shadow[0] <= CTRL_DEFAULT;
			st.active <= {NREG{REG_DEFAULT}};
			st.active[0] <= CTRL_DEFAULT;
			st.enable <= CONTROL_EN_RESET;
			st.oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flops; bus never waits or errors
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = st.rdata;
	assign sdio_out = st.sd_out;
	assign sdio_oe_n = st.oe_n;

endmodule

// File: verif/tws_host.sv
// Serial host model that frames cycles on the three-wire port
`timescale 1ns/1ps
module tws_host (
	output logic sclk, // Shift clock, idle low between frames
	output logic cs_n, // Select, active low, idle high
	output logic sdio_in, // Resolved data pin level
	input wire logic sdio_out, // Device drive value
	input wire logic sdio_oe_n // Device enable, active low
);
	logic drv, val, last;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		drv = 1'b0;
		val = 1'b0;
		last = 1'b0;
	end
	// Undriven pin flips so a stale level never passes as data
	always_comb begin
		if (!sdio_oe_n)
			sdio_in = sdio_out;
		else if (drv)
			sdio_in = val;
		else
			sdio_in = ~last;
	end
	// Remember the last level anyone drove onto the pin
	always @(sdio_oe_n, sdio_out, drv, val) begin
		if (!sdio_oe_n)
			last = sdio_out;
		else if (drv)
			last = val;
	end
	function automatic logic [15:0] rv(input logic [15:0] x, input int n);
		rv = 16'h0;
		for (int i = 0; i < n; i++)
			rv[i] = x[n - 1 - i];
	endfunction
	// Data set after each fall, held over the rise
	task shift(input int n, input logic [31:0] v, input bit d,
		output logic [31:0] r);
		r = 32'h0;
		for (int i = n - 1; i >= 0; i--) begin
			drv = d;
			val = v[i];
			#32 sclk = 1'b1;
			r[i] = sdio_in;
			#32 sclk = 1'b0;
		end
	endtask
	// Select low, instruction, bytes; stalls on boundaries
	task xfer(input logic [15:0] ins, input int nb, input logic [31:0] d,
		input bit st, input bit lsb, output logic [31:0] r);
		logic [31:0] b;
		r = 32'h0;
		// Start off the clock edge so the pin samplers see no race
		#3;
		cs_n = 1'b0;
		#40 shift(16, lsb ? rv(ins, 16) : ins, 1'b1, b);
		for (int k = nb - 1; k >= 0; k--) begin
			if (st && k < nb - 1) begin
				#8 cs_n = 1'b1;
				#80 cs_n = 1'b0;
				#40;
			end
			shift(8, lsb ? rv(d[k*8+:8], 8) : d[k*8+:8], !ins[15], b);
			r[k*8+:8] = lsb ? 8'(rv(b[7:0], 8)) : b[7:0];
		end
		// Select rises only after the last whole byte
		#40 cs_n = 1'b1;
		drv = 1'b0;
		#80;
	endtask
endmodule

// File: verif/tws_port_assertions.sv
// Port-level assertions for the three-wire serial control port
`timescale 1ns/1ps
module tws_port_assertions (
	input logic clk, // System clock
	input logic arst_n, // Reset, active low
	input logic hsel, // AHB select
	input logic [31:0] haddr, // AHB address
	input logic [1:0] htrans, // AHB transfer type
	input logic hwrite, // AHB write flag
	input logic hready, // AHB ready
	input logic hreadyout, // Slave ready
	input logic [31:0] hrdata, // Read data
	input logic hresp, // Response
	input logic cs_n, // Select, active low
	input logic sdio_out, // Data drive value
	input logic sdio_oe_n // Data enable, active low
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Read taken this edge, split by region of the map
	logic rd_tk, map_rd;
	assign rd_tk = hsel && htrans[1] && hready && !hwrite;
	assign map_rd = rd_tk && haddr[31:9] == 23'h0;
	property p_rdy; hreadyout && !hresp; endproperty
	a_rdy: assert property (p_rdy) else $error("bus stalled or errored");
	property p_hold; !(hsel && htrans[1] && hready) |=> $stable(hrdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; map_rd && haddr[8:2] inside {[7'h35:7'h3f]}
		|=> hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
	property p_byte; map_rd && haddr[8:2] <= 7'h34 |=> hrdata[31:8] == 0;
	endproperty
	a_byte: assert property (p_byte) else $error("map read over 8 bits");
	property p_ctrl; map_rd && haddr[8:2] == 7'h00 |=> !hrdata[7] &&
		hrdata[4] && hrdata[3:0] == {hrdata[4], hrdata[5],
		hrdata[6], hrdata[7]}; endproperty
	a_ctrl: assert property (p_ctrl) else $error("control byte");
	property p_rel; cs_n[*5] |-> sdio_oe_n; endproperty
	a_rel: assert property (p_rel) else $error("pin driven");
	property p_drv; $fell(sdio_oe_n) |-> !cs_n; endproperty
	a_drv: assert property (p_drv) else $error("drive unselected");
	property p_still; cs_n[*6] |-> $stable(sdio_out); endproperty
	a_still: assert property (p_still) else $error("data moved");
endmodule
bind tws_port tws_port_assertions chk_u (.*);

// File: verif/tws_port_tb.sv
// Self-checking bench for the three-wire serial control port
`timescale 1ns/1ps
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("unexpected t=%0t got %h exp %h", $time, g, e); \
	end \
end
module tws_port_tb;
	import tws_pkg::*;
	logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q, r, d;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic sclk, cs_n, sdio_in, sdio_out, sdio_oe_n;
	int err_count, tests_run;
	tws_port dut_u (.*);
	tws_host host_u (.*);
	assign hready = hreadyout;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Instruction word: direction, length, start address
	function automatic logic [15:0] ins(bit rd, logic [1:0] ln,
		logic [12:0] a);
		return {rd, ln, a};
	endfunction
	// Control byte with the high nibble mirrored low
	function automatic logic [31:0] cexp(bit lsb);
		return lsb ? 32'h5a : 32'h18;
	endfunction
	// One single AHB transfer, waiting on hready in both phases
	task ahb(input logic w, input logic [6:0] i, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {23'h0, i, 2'h0};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task rd(input logic [6:0] i, input logic [31:0] e);
		ahb(1'b0, i, 32'h0);
		`CHK(q, e)
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard, far beyond the few thousand cycles expected
	initial begin
		#400000;
		err_count++;
		close_out();
	end
	initial begin
		void'($urandom(32'hef4b40a5));
		arst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		hsize = 3'h2;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd(IDX_CONTROL, 32'h1);
		rd(7'h3a, 32'h0);
		rd(7'h00, cexp(0));
		host_u.xfer(ins(1, 0, ADDR_CTRL), 1, 0, 0, 0, r);
		`CHK(r[7:0], 8'h18)
		$display("test reset done");
		// Stalled two-byte write stays in the shadows
		d = $urandom;
		host_u.xfer(ins(0, 2'h1, 13'h11), 2, d, 1, 0, r);
		rd(7'h11, 32'h0);
		host_u.xfer(ins(0, 0, ADDR_RDBK), 1, 1, 0, 0, r);
		rd(7'h11, d[15:8]);
		rd(7'h10, d[7:0]);
		// Select rising mid-byte drops the byte
		#3 host_u.cs_n = 1'b0;
		#40 host_u.shift(16, ins(0, 0, 13'h20), 1, r);
		host_u.shift(4, 32'hf, 1, r);
		#40 host_u.cs_n = 1'b1;
		#100 rd(7'h20, 32'h0);
		host_u.xfer(ins(0, 0, ADDR_UPDT), 1, 1, 0, 0, r);
		host_u.xfer(ins(0, 0, ADDR_RDBK), 1, 0, 0, 0, r);
		rd(7'h10, d[7:0]);
		rd(7'h05, 32'h0);
		host_u.xfer(ins(1, 2'h3, 13'h11), 3, 0, 0, 0, r);
		`CHK(r[23:0], {d[15:0], 8'h0})
		$display("test shadow done");
		// Bit order switches only after an update
		host_u.xfer(ins(0, 0, ADDR_CTRL), 1, 32'h40, 0, 0, r);
		rd(7'h00, cexp(0));
		host_u.xfer(ins(0, 0, ADDR_UPDT), 1, 1, 0, 0, r);
		rd(7'h00, cexp(1));
		d = $urandom;
		host_u.xfer(ins(0, 2'h1, 13'h30), 2, d, 0, 1, r);
		host_u.xfer(ins(0, 0, ADDR_UPDT), 1, 1, 0, 1, r);
		rd(7'h31, d[7:0]);
		host_u.xfer(ins(1, 2'h1, 13'h30), 2, 0, 0, 1, r);
		`CHK(r[15:0], d[15:0])
		$display("test order done");
		// Soft reset brings back defaults and MSB order
		host_u.xfer(ins(0, 0, ADDR_CTRL), 1, 32'h20, 0, 1, r);
		rd(7'h00, cexp(0));
		rd(7'h30, 32'h0);
		host_u.xfer(ins(1, 0, ADDR_CTRL), 1, 0, 0, 0, r);
		`CHK(r[7:0], 8'h18)
		$display("test soft reset done");
		// Stalled write aborted by a short partial byte
		d = $urandom;
		#3 host_u.cs_n = 1'b0;
		#40 host_u.shift(16, ins(0, 2'h1, 13'h22), 1, r);
		host_u.shift(8, d[7:0], 1, r);
		#8 host_u.cs_n = 1'b1;
		#80 host_u.cs_n = 1'b0;
		#40 host_u.shift(3, 32'h7, 1, r);
		#40 host_u.cs_n = 1'b1;
		host_u.drv = 1'b0;
		#80 host_u.xfer(ins(0, 0, ADDR_RDBK), 1, 1, 0, 0, r);
		rd(7'h22, d[7:0]);
		rd(7'h21, 32'h0);
		// Pins are ignored while the port is disabled
		ahb(1'b1, IDX_CONTROL, 32'h0);
		rd(IDX_CONTROL, 32'h0);
		host_u.xfer(ins(0, 0, 13'h23), 1, 32'h3c, 0, 0, r);
		ahb(1'b1, IDX_CONTROL, 32'h1);
		rd(7'h23, 32'h0);
		ahb(1'b0, IDX_STATUS, 32'h0);
		`CHK(q[3:0], 4'h0)
		$display("test abort done");
		close_out();
	end
endmodule
